// [core/rsp_slave_port.sv]
// serial slave port of the radio: link-side shifter, status byte and write crossing
// Summary of operation
// [R1] every byte moves most significant bit first, both directions
// [R2] a frame opens with header: read/write flag, burst flag, 6-bit address
// [R3] status byte is shifted out while the header is shifted in
// [R4] master keeps chip select low for the whole transfer
// [R5] serial output goes low when crystal is stable; master waits for it
// [R6] serial output falls at once on select unless crystal not yet stable
// [R7] burst loads address counter from header, steps once per further byte
// [R8] burst stays all reads or all writes until chip select rises
// [R9] with increment enable at 0 the burst address never steps
// [R10] master leaves a gap between burst write bytes of 100 or 125 ns
// [R11] chip reset returns all state to defaults; master reconfigures afterwards; rst clears only core-clock state, deselect clears link side, not the handoff
// [R12] serial input sampled on rising clock edge, output changed on falling edge
// [R13] header flag 1 means read, 0 means write
// [R14] status byte also goes out during write data bytes
// [R15] status bit 7 is active-low ready, high until crystal stable
// [R16] status bits 6..4 carry the encoded main state
module rsp_slave_port #(
   parameter int FIFO_DEPTH = rsp_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic serialClock,
   input wire logic chipSelectLow,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEnable,
   input wire logic crystalStable,
   input wire logic [2:0] mainState,
   input wire logic burstIncrementEnable,
   output logic [rsp_pkg::ADDR_W-1:0] readAddress,
   input wire logic [rsp_pkg::BYTE_W-1:0] readData,
   output logic writeValid,
   input wire logic writeReady,
   output logic [rsp_pkg::ADDR_W-1:0] writeAddress,
   output logic [rsp_pkg::BYTE_W-1:0] writeData,
   input wire logic overflowClear,
   output logic writeOverflow
);
   generate
      if (FIFO_DEPTH < 2) begin : gBadDepth
         $error("rsp_slave_port needs FIFO_DEPTH of at least 2");
      end
   endgenerate

   // ---------------- core clock side ----------------
   logic csSync2_r;
   logic crySync2_r;
   logic readyLow_r, readyLow_nxt;
   logic [7:0] statusHold_r, statusHold_nxt;
   logic incHold_r, incHold_nxt;
   logic reqSync2_r;
   logic ack_r, ack_nxt;
   logic pend_r, pend_nxt;
   logic [rsp_pkg::WORD_W-1:0] pendWord_r, pendWord_nxt;
   logic overflow_r, overflow_nxt;
   logic fifoInReady;
   logic [rsp_pkg::WORD_W-1:0] fifoOut;

   // ---------------- link clock side ----------------
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [6:0] inShift_r, inShift_nxt;
   rsp_pkg::rsp_phase_t phase_r, phase_nxt;
   logic rw_r, rw_nxt;
   logic burst_r, burst_nxt;
   logic [rsp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [rsp_pkg::WORD_W-1:0] wrHold_r, wrHold_nxt;
   logic wrToggle_r = 1'b0;
   logic wrToggle_nxt;
   logic fell_r, fell_nxt;
   logic [7:0] outShift_r, outShift_nxt;
   logic [7:0] byteIn;
   logic [7:0] sendByte;

   // select, crystal and write toggle each pass two flops; only the second stage is read
   logic [2:0] syncIn;
   logic [2:0] syncOut;
   assign syncIn = {wrToggle_r, crystalStable, ~chipSelectLow};
   generate
      for (genvar s = 0; s < 3; s++) begin : gSync
         logic stage1_r;
         logic stage2_r;
         always_ff @(posedge mclk) begin
            stage1_r <= syncIn[s];
            stage2_r <= stage1_r;
         end
         assign syncOut[s] = stage2_r;
      end
   endgenerate
   assign csSync2_r = syncOut[0];
   assign crySync2_r = syncOut[1];
   assign reqSync2_r = syncOut[2];

   always_comb begin
      readyLow_nxt = ~crySync2_r; // [R15] [R6]
      statusHold_nxt = statusHold_r;
      incHold_nxt = incHold_r;
      // context is frozen for the frame so the link side may read it without a handshake
      if (!csSync2_r) begin
         statusHold_nxt = {readyLow_r, mainState, rsp_pkg::STATUS_RESERVED}; // [R16] [R15]
         incHold_nxt = burstIncrementEnable; // [R9]
      end
      ack_nxt = ack_r;
      pend_nxt = pend_r && !fifoInReady;
      pendWord_nxt = pendWord_r;
      overflow_nxt = overflow_r && !overflowClear;
      // a new byte arrived from the link; the hold register stays put for a byte time
      if (reqSync2_r != ack_r) begin // [R10]
         ack_nxt = reqSync2_r;
         if (pend_r && !fifoInReady) begin
            overflow_nxt = 1'b1;
         end else begin
            pend_nxt = 1'b1;
            pendWord_nxt = wrHold_r;
         end
      end
      if (rst) begin // [R11]
         readyLow_nxt = 1'b1;
         statusHold_nxt = rsp_pkg::STATUS_RESET;
         incHold_nxt = 1'b1;
         ack_nxt = reqSync2_r;
         pend_nxt = 1'b0;
         pendWord_nxt = '0;
         overflow_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      readyLow_r <= readyLow_nxt;
      statusHold_r <= statusHold_nxt;
      incHold_r <= incHold_nxt;
      ack_r <= ack_nxt;
      pend_r <= pend_nxt;
      pendWord_r <= pendWord_nxt;
      overflow_r <= overflow_nxt;
   end

   rsp_fifo #(
      .WIDTH(rsp_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) uFifo (
      .mclk(mclk),
      .rst(rst),
      .inValid(pend_r),
      .inReady(fifoInReady),
      .inData(pendWord_r),
      .outValid(writeValid),
      .outReady(writeReady),
      .outData(fifoOut)
   );

   assign writeAddress = fifoOut[rsp_pkg::WORD_W-1:rsp_pkg::BYTE_W];
   assign writeData = fifoOut[rsp_pkg::BYTE_W-1:0];
   assign writeOverflow = overflow_r;

   // ---------------- link logic, rising edge ----------------
   always_comb begin
      byteIn = {inShift_r, serialIn}; // [R1]
      inShift_nxt = byteIn[6:0]; // [R12]
      bitCnt_nxt = bitCnt_r + 1'b1;
      phase_nxt = phase_r;
      rw_nxt = rw_r;
      burst_nxt = burst_r;
      addr_nxt = addr_r;
      wrHold_nxt = wrHold_r;
      wrToggle_nxt = wrToggle_r;
      if (bitCnt_r == rsp_pkg::BIT_COUNT_LAST) begin
         case (phase_r)
            rsp_pkg::RSP_PH_HEADER: begin
               rw_nxt = (byteIn[rsp_pkg::HDR_RW_BIT] == rsp_pkg::HDR_RW_READ); // [R13] [R2]
               burst_nxt = byteIn[rsp_pkg::HDR_BURST_BIT]; // [R2]
               addr_nxt = byteIn[rsp_pkg::ADDR_W-1:0]; // [R2] [R7]
               phase_nxt = rsp_pkg::RSP_PH_DATA;
            end
            rsp_pkg::RSP_PH_DATA: begin
               if (!rw_r) begin
                  wrHold_nxt = {addr_r, byteIn};
                  wrToggle_nxt = ~wrToggle_r;
               end
               // a burst keeps its direction until the frame ends
               if (burst_r) begin // [R8]
                  if (incHold_r) begin // [R9]
                     addr_nxt = addr_r + rsp_pkg::ADDR_STEP; // [R7]
                  end
               end else begin
                  phase_nxt = rsp_pkg::RSP_PH_HEADER;
               end
            end
            default: begin
               phase_nxt = rsp_pkg::RSP_PH_HEADER;
            end
         endcase
      end
   end

   // chip select high ends the frame and clears the shifter, even mid-byte
   always_ff @(posedge serialClock or posedge chipSelectLow) begin
      if (chipSelectLow) begin // [R4] [R8]
         bitCnt_r <= rsp_pkg::BIT_COUNT_RESET;
         inShift_r <= '0;
         phase_r <= rsp_pkg::RSP_PH_HEADER;
         rw_r <= 1'b0;
         burst_r <= 1'b0;
         addr_r <= '0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         inShift_r <= inShift_nxt;
         phase_r <= phase_nxt;
         rw_r <= rw_nxt;
         burst_r <= burst_nxt;
         addr_r <= addr_nxt;
      end
   end

   // the handoff word and its toggle must survive the end of the frame
   always_ff @(posedge serialClock) begin
      wrHold_r <= wrHold_nxt;
      wrToggle_r <= wrToggle_nxt;
   end

   // ---------------- link logic, falling edge ----------------
   always_comb begin
      sendByte = statusHold_r; // [R3] [R14]
      if (phase_r == rsp_pkg::RSP_PH_DATA && rw_r) begin
         sendByte = readData;
      end
      fell_nxt = 1'b1;
      if (!fell_r) begin
         // msb of the first status byte already sits on the pin before any edge
         outShift_nxt = {statusHold_r[6:0], 1'b0}; // [R3] [R1]
      end else if (bitCnt_r == rsp_pkg::BIT_COUNT_RESET) begin
         outShift_nxt = sendByte; // [R12]
      end else begin
         outShift_nxt = {outShift_r[6:0], 1'b0}; // [R1]
      end
   end

   always_ff @(negedge serialClock or posedge chipSelectLow) begin
      if (chipSelectLow) begin
         fell_r <= 1'b0;
         outShift_r <= '0;
      end else begin
         fell_r <= fell_nxt;
         outShift_r <= outShift_nxt;
      end
   end

   // before the first falling edge the pin shows the live ready flag
   assign serialOut = fell_r ? outShift_r[7] : readyLow_r; // [R5] [R6]
   assign serialOutEnable = ~chipSelectLow;
   // read data is taken half a clock after the address settles; the core must mux it
   assign readAddress = addr_r;
endmodule : rsp_slave_port

// [common/rsp_pkg.sv]
// constants and types shared by the radio serial slave port
package rsp_pkg;
   localparam int ADDR_W = 6;
   localparam int BYTE_W = 8;
   localparam int WORD_W = ADDR_W + BYTE_W;
   localparam int FIFO_DEPTH = 8;
   localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
   localparam logic [2:0] BIT_COUNT_FIRST = 3'h1;
   localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
   localparam int HDR_RW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam logic HDR_RW_READ = 1'b1;
   localparam int STATUS_READY_BIT = 7;
   localparam int STATUS_STATE_HI = 6;
   localparam int STATUS_STATE_LO = 4;
   localparam logic [3:0] STATUS_RESERVED = 4'h0;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [5:0] ADDR_STEP = 6'h01;

   // main state as reported in status bits 6..4
   typedef enum logic [2:0] {
      RSP_ST_IDLE = 3'h0,
      RSP_ST_RECEIVE = 3'h1,
      RSP_ST_TRANSMIT = 3'h2,
      RSP_ST_FAST_TRANSMIT_READY = 3'h3,
      RSP_ST_CALIBRATE = 3'h4,
      RSP_ST_SETTLING = 3'h5,
      RSP_ST_RECEIVE_FIFO_ERROR = 3'h6,
      RSP_ST_TRANSMIT_FIFO_ERROR = 3'h7
   } rsp_main_state_t;

   // serial frame phase, one-hot
   typedef enum logic [1:0] {
      RSP_PH_HEADER = 2'b01,
      RSP_PH_DATA = 2'b10
   } rsp_phase_t;
endpackage : rsp_pkg

// [core/rsp_fifo.sv]
// small synchronous fifo with valid/ready on both sides
module rsp_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : gBadParam
         $error("rsp_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
      end
   endgenerate

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic [PTR_W:0] count_r, count_nxt;
   logic push, pop;

   assign inReady = (count_r != COUNT_FULL);
   assign outValid = (count_r != '0);
   assign outData = mem_r[rdPtr_r];

   always_comb begin
      push = inValid && inReady;
      pop = outValid && outReady;
      mem_nxt = mem_r;
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      count_nxt = count_r;
      if (push) begin
         mem_nxt[wrPtr_r] = inData;
         wrPtr_nxt = (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
         rdPtr_nxt = (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
      if (rst) begin
         wrPtr_nxt = '0;
         rdPtr_nxt = '0;
         count_nxt = '0;
      end
   end

   // storage holds no reset: empty entries are never shown
   always_ff @(posedge mclk) begin
      mem_r <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
   end
endmodule : rsp_fifo

// [verification/rsp_slave_port_properties.sv]
// concurrent checks on the pins of the radio serial slave port
module rsp_slave_port_properties #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic serialClock,
   input wire logic chipSelectLow,
   input wire logic serialOut,
   input wire logic serialOutEnable,
   input wire logic crystalStable,
   input wire logic [5:0] readAddress,
   input wire logic writeValid,
   input wire logic writeReady,
   input wire logic [5:0] writeAddress,
   input wire logic [7:0] writeData,
   input wire logic writeOverflow
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cbMclk @(posedge mclk);
   endclocking
   default disable iff (rst);
   AST_OE: assert property (serialOutEnable == !chipSelectLow)
      else $error("output enable does not follow select");
   AST_RST: assert property (disable iff (1'h0) $fell(rst) |-> !writeValid && !writeOverflow)
      else $error("state not cleared by reset");
   AST_IDLE_ADDR: assert property (chipSelectLow |-> readAddress == 6'h00)
      else $error("address counter not cleared by deselect");
   AST_HOLD: assert property (
      writeValid && !writeReady |=> writeValid && $stable(writeData) && $stable(writeAddress))
      else $error("fifo head changed before it was taken");
   AST_BUSY: assert property (
      (!crystalStable && chipSelectLow) [*4] ##1 $fell(chipSelectLow) |-> serialOut)
      else $error("ready shown while crystal unstable");
   AST_READY: assert property (
      (crystalStable && chipSelectLow) [*4] ##1 $fell(chipSelectLow) |-> !serialOut)
      else $error("serial output not low after select");
   // serial output may only move while the link clock is low
   AST_SO_STABLE: assert property (
      serialClock && $past(serialClock) && !chipSelectLow && !$past(chipSelectLow)
      |-> $stable(serialOut))
      else $error("serial output moved in clock high phase");
   AST_ADDR_STABLE: assert property (
      !serialClock && !$past(serialClock) && !chipSelectLow && !$past(chipSelectLow)
      |-> $stable(readAddress))
      else $error("address moved without a rising link edge");
endmodule : rsp_slave_port_properties

bind rsp_slave_port rsp_slave_port_properties #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.mclk, .rst,
   .serialClock, .chipSelectLow, .serialOut, .serialOutEnable, .crystalStable, .readAddress,
   .writeValid, .writeReady, .writeAddress, .writeData, .writeOverflow);

// [verification/rsp_host_model.sv]
// serial master model standing in for the host microcontroller
module rsp_host_model (
   output logic serialClock,
   output logic chipSelectLow,
   output logic serialIn,
   input wire logic serialOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serialClock = 1'h0;
      chipSelectLow = 1'h1;
      serialIn = 1'h0;
   end
   task automatic select(input logic v);
      chipSelectLow = v;
   endtask : select
   // bounded wait, so a device that never gets ready cannot hang the run
   task automatic start();
      int i;
      i = 0;
      chipSelectLow = 1'h0;
      while (serialOut !== 1'h0 && i < 100) begin
         #20;
         i++;
      end
      #60;
   endtask : start
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         #16 serialIn = tx[i];
         #16 serialClock = 1'h1;
         rx[i] = serialOut;
         #32 serialClock = 1'h0;
      end
      #128 serialIn = ~serialIn;
   endtask : xfer
   task automatic stop();
      #200 chipSelectLow = 1'h1;
      serialIn = ~serialIn;
      #100;
   endtask : stop
endmodule : rsp_host_model

// [verification/rsp_slave_port_test.sv]
// self-checking bench of the radio serial slave port
module rsp_slave_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic crystalStable = 1'h0;
   logic burstIncrementEnable = 1'h1;
   logic writeReady = 1'h0;
   logic overflowClear = 1'h0;
   logic [2:0] mainState = 3'h0;
   logic [7:0] readData = 8'h00;
   logic [7:0] rx;
   wire logic serialClock, chipSelectLow, serialIn, serialOut, serialOutEnable;
   wire logic writeValid, writeOverflow;
   wire logic [5:0] readAddress, writeAddress;
   wire logic [7:0] writeData;
   wire logic soLine;
   // a released line shows the opposite of its last level, so a stale read shows up
   assign soLine = serialOutEnable ? serialOut : ~serialOut;
   int errors = 0;
   int n_tests = 0;
   rsp_slave_port i_rsp_slave_port (.mclk, .rst, .serialClock, .chipSelectLow, .serialIn,
      .serialOut, .serialOutEnable, .crystalStable, .mainState, .burstIncrementEnable,
      .readAddress, .readData, .writeValid, .writeReady, .writeAddress, .writeData,
      .overflowClear, .writeOverflow);
   rsp_host_model i_rsp_host_model (.serialClock, .chipSelectLow, .serialIn, .serialOut(soLine));
   initial forever #10 mclk = ~mclk;
   // register file stand-in: data is a fixed function of the address
   always @(posedge mclk) readData <= {2'h0, readAddress} ^ 8'hA0;
   task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic pop(input logic [14:0] exp);
      @(negedge mclk) check("fifo head", {writeValid, writeAddress, writeData}, exp);
      @(posedge mclk) writeReady <= 1'h1;
      @(posedge mclk) writeReady <= 1'h0;
   endtask : pop
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #100us;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      repeat (6) @(posedge mclk);
      i_rsp_host_model.select(1'h0);
      #50 check("not ready", {serialOutEnable, serialOut}, 15'h3);
      i_rsp_host_model.select(1'h1);
      $display("test ready flag done");
      @(posedge mclk) crystalStable <= 1'h1;
      repeat (10) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) mainState <= 3'(i);
         i_rsp_host_model.start();
         i_rsp_host_model.xfer(8'h80 | 8'(i), rx);
         check("status", rx, {1'h0, 3'(i), 4'h0});
         i_rsp_host_model.xfer(8'h00, rx);
         check("read byte", rx, 8'(i) ^ 8'hA0);
         i_rsp_host_model.stop();
      end
      $display("test status and single read done");
      // writer stalls so the fifo fills and the last byte is dropped
      i_rsp_host_model.start();
      i_rsp_host_model.xfer(8'h7C, rx);
      for (int k = 0; k < 10; k++) begin
         i_rsp_host_model.xfer(8'(k), rx);
         check("data status", rx, 15'h70);
      end
      i_rsp_host_model.stop();
      repeat (10) @(posedge mclk);
      check("overflow", writeOverflow, 15'h1);
      for (int k = 0; k < 9; k++) pop({1'h1, 6'h3C + 6'(k), 8'(k)});
      @(negedge mclk) check("drained", writeValid, 15'h0);
      @(posedge mclk) overflowClear <= 1'h1;
      @(posedge mclk) overflowClear <= 1'h0;
      @(negedge mclk) check("overflow clear", writeOverflow, 15'h0);
      $display("test burst write and overflow done");
      @(posedge mclk) burstIncrementEnable <= 1'h0;
      i_rsp_host_model.start();
      i_rsp_host_model.xfer(8'h4A, rx);
      i_rsp_host_model.xfer(8'h44, rx);
      i_rsp_host_model.xfer(8'h55, rx);
      i_rsp_host_model.stop();
      repeat (10) @(posedge mclk);
      pop({1'h1, 6'h0A, 8'h44});
      pop({1'h1, 6'h0A, 8'h55});
      @(posedge mclk) burstIncrementEnable <= 1'h1;
      $display("test fixed address burst done");
      // two single writes in one frame, then a chip reset with data still queued
      i_rsp_host_model.start();
      i_rsp_host_model.xfer(8'h05, rx);
      i_rsp_host_model.xfer(8'hA5, rx);
      check("write status", rx, 15'h70);
      i_rsp_host_model.xfer(8'h06, rx);
      check("header status", rx, 15'h70);
      i_rsp_host_model.xfer(8'h5A, rx);
      i_rsp_host_model.stop();
      repeat (10) @(posedge mclk);
      pop({1'h1, 6'h05, 8'hA5});
      @(negedge mclk) check("head", {writeValid, writeAddress, writeData}, 15'h465A);
      @(posedge mclk) rst <= 1'h1;
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      @(negedge mclk) check("reset", {writeValid, writeOverflow}, 15'h0);
      $display("test single write and reset done");
      i_rsp_host_model.start();
      i_rsp_host_model.xfer(8'hD0, rx);
      for (int k = 0; k < 3; k++) begin
         i_rsp_host_model.xfer(8'h00, rx);
         check("burst read", rx, (8'h10 + 8'(k)) ^ 8'hA0);
      end
      i_rsp_host_model.stop();
      $display("test burst read done");
      print_verdict();
   end
endmodule : rsp_slave_port_test
